// >>> dsc_host_model.sv
// Host microcontroller model that drives the serial link of the switch.
`timescale 1ns/1ps
module dsc_host_model
(
    output logic sclk_o,
    output logic csn_o,
    output logic si_o,
    input wire logic so_i
);
    // Idle link: clock parked low, select released high.
    initial
    begin
        sclk_o = 1'b0;
        csn_o = 1'b1;
        si_o = 1'b0;
    end
    // Shifts n bits MSB first in one select window, 160 ns clock.
    task automatic xfer(input logic [31:0] w, input int n, output logic [31:0] r);
        r = '0;
        #5; // Stay off the system clock edge.
        csn_o = 1'b0;
        for (int i = n - 1; i >= 0; i--)
        begin
            si_o = w[i];
            #90;
            sclk_o = 1'b1;
            r = {r[30:0], so_i};
            #70;
            sclk_o = 1'b0;
        end
        #90;
        csn_o = 1'b1;
        si_o = ~si_o; // No stale bit on release.
        #200;
    endtask
endmodule // dsc_host_model

// >>> dsc_pkg.sv
// Shared constants for the dual switch control block.
package dsc_pkg;
    localparam int FRAME_W = 16;
    localparam int BITCNT_W = 5;
    localparam logic [4:0] FRAME_BITS = 5'h10;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;
    localparam int PWM_W = 8;
    // Register byte offsets.
    localparam logic [4:0] REG_STATUS = 5'h00;
    localparam logic [4:0] REG_MASK = 5'h04;
    localparam logic [4:0] REG_CTRL = 5'h08;
    localparam logic [4:0] REG_STATE = 5'h0c;
    localparam logic [4:0] REG_FRAME = 5'h10;
    // Event bits of status and mask.
    localparam int EV_W = 4;
    localparam int EV_FRAME = 0;
    localparam int EV_BADFRAME = 1;
    localparam int EV_FAILSAFE = 2;
    localparam int EV_FAULT = 3;
    // Control register.
    localparam int CTRL_WDOG_EN = 0;
    localparam logic [DATA_W-1:0] CTRL_RST = 16'h0001;
    // Serial command field and codes.
    localparam int FR_CMD_HI = 15;
    localparam int FR_CMD_LO = 12;
    localparam logic [3:0] CMD_MODE = 4'h1;
    localparam logic [3:0] CMD_SENSE = 4'h2;
    localparam logic [3:0] CMD_DUTY_A = 4'h3;
    localparam logic [3:0] CMD_DUTY_B = 4'h4;
    localparam logic [3:0] CMD_RETRY = 4'h5;
    localparam int SENSE_TEMP = 0;
    localparam int SENSE_GAIN = 1;
    localparam int SENSE_CHAN = 2;
    // Channel drive modes.
    localparam logic [1:0] MODE_DIRECT = 2'h0;
    localparam logic [1:0] MODE_INT = 2'h1;
    localparam logic [1:0] MODE_EXT = 2'h2;
    // Synchroniser lanes.
    localparam int SY_W = 15;
    localparam int SY_SCLK = 0;
    localparam int SY_CSN = 1;
    localparam int SY_SI = 2;
    localparam int SY_PWMCLK = 3;
    localparam int SY_IN = 4;
    localparam int SY_PROF = 6;
    localparam int SY_RSTN = 8;
    localparam int SY_OC = 9;
    localparam int SY_SC = 11;
    localparam int SY_OT = 13;
    localparam logic [SY_W-1:0] SY_RST = 15'h0102;
    // Timing.
    localparam int CLK_MHZ = 50;
    localparam int WDOG_TIME_US = 1000;
    localparam int RETRY_TIME_US = 500;
    localparam int PWM_TICK_NS = 2000;
    localparam int SETTLE_NS = 1000;
    localparam int WDOG_CYC = WDOG_TIME_US * CLK_MHZ;
    localparam int RETRY_CYC = RETRY_TIME_US * CLK_MHZ;
    localparam int PWM_TICK_CYC = (PWM_TICK_NS * CLK_MHZ + 999) / 1000;
    localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int TMR_W = 20;
    localparam int SHORT_W = 8;
endpackage

// >>> dsc_spi_rx.sv
// Serial frame port sampled on the system clock, with daisy-chain output.
`timescale 1ns/1ps
module dsc_spi_rx
    import dsc_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic sclk_i,
    input wire logic csn_i,
    input wire logic si_i,
    input wire logic [FRAME_W-1:0] tx_word_i,
    output logic so_o,
    output logic [FRAME_W-1:0] frame_o,
    output logic frame_ok_o,
    output logic frame_bad_o
);
    typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_SHIFT = 2'b10} dsc_spi_st_t;

    dsc_spi_st_t st_q, st_d;
    logic [FRAME_W-1:0] sh_q, sh_d;
    logic [BITCNT_W-1:0] cnt_q, cnt_d;
    logic over_q, over_d;
    logic so_q, so_d;
    logic sclk_q, csn_q;
    logic ok_q, ok_d, bad_q, bad_d;
    logic [FRAME_W-1:0] fr_q, fr_d;

    // Mode 0: sample on rising serial clock, present next bit on falling.
    always_comb
    begin
        st_d = st_q;
        sh_d = sh_q;
        cnt_d = cnt_q;
        over_d = over_q;
        so_d = so_q;
        ok_d = 1'b0;
        bad_d = 1'b0;
        fr_d = fr_q;
        case (st_q)
            ST_IDLE:
            begin
                if (csn_q && !csn_i)
                begin
                    st_d = ST_SHIFT;
                    sh_d = tx_word_i;
                    so_d = tx_word_i[FRAME_W-1];
                    cnt_d = '0;
                    over_d = 1'b0;
                end
            end
            ST_SHIFT:
            begin
                if (csn_i)
                begin
                    // One whole frame per select, acted on at deselect.
                    st_d = ST_IDLE;
                    if (cnt_q == FRAME_BITS && !over_q)
                    begin
                        ok_d = 1'b1;
                        fr_d = sh_q;
                    end
                    else
                    begin
                        bad_d = 1'b1;
                    end
                end
                else if (sclk_i && !sclk_q)
                begin
                    sh_d = {sh_q[FRAME_W-2:0], si_i};
                    if (cnt_q == FRAME_BITS)
                        over_d = 1'b1;
                    else
                        cnt_d = cnt_q + 5'h01;
                end
                else if (!sclk_i && sclk_q)
                begin
                    so_d = sh_q[FRAME_W-1];
                end
            end
            default:
            begin
                st_d = ST_IDLE;
            end
        endcase
    end

    // State registers.
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            st_q <= ST_IDLE;
            sh_q <= '0;
            cnt_q <= '0;
            over_q <= 1'b0;
            so_q <= 1'b0;
            sclk_q <= 1'b0;
            csn_q <= 1'b1;
            ok_q <= 1'b0;
            bad_q <= 1'b0;
            fr_q <= '0;
        end
        else
        begin
            st_q <= st_d;
            sh_q <= sh_d;
            cnt_q <= cnt_d;
            over_q <= over_d;
            so_q <= so_d;
            sclk_q <= sclk_i;
            csn_q <= csn_i;
            ok_q <= ok_d;
            bad_q <= bad_d;
            fr_q <= fr_d;
        end
    end

    assign so_o = so_q;
    assign frame_o = fr_q;
    assign frame_ok_o = ok_q;
    assign frame_bad_o = bad_q;
endmodule // dsc_spi_rx

// >>> dsc_sync.sv
// Two-flop synchroniser for pins that arrive from outside the clock domain.
`timescale 1ns/1ps
module dsc_sync
#(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
)
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] q_q;

    // First stage feeds only the second stage.
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            meta_q <= RST_VAL;
            q_q <= RST_VAL;
        end
        else
        begin
            meta_q <= d_i;
            q_q <= meta_q;
        end
    end

    assign q_o = q_q;
endmodule // dsc_sync

// >>> dsc_top.sv
// Control pins, serial configuration, channels and diagnostics of the switch.
// Notes on behaviour
// - Traffic uses 16-bit frames, link up to 8 MHz.
// - Host link loss enters fail-safe, still operational.
// - Fail-safe indicator pulled low on fail-safe entry.
// - Fault indicator pulled low in fault mode.
// - Device reset restores configuration and fault state.
// - Reset sleeps unless a direct input is active.
// - Direct inputs switch each output; open reads off.
// - Profile pins choose bulb or motor per channel.
// - Each channel: direct, internal clock or external clock.
// - External mode counts PWM on the clock pin.
// - Host picks sense source and sensitivity serially.
// - Per-channel protection with configurable automatic retry.
// - Monitor sync pulled low while sense is accurate.
// - Serial data can chain through to the next device.
//
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
module dsc_top
    import dsc_pkg::*;
#(
    parameter int WDOG_CYCLES = WDOG_CYC,
    parameter int RETRY_CYCLES = RETRY_CYC,
    parameter logic [3:0] DEV_ID = 4'ha // Arbitrary value.
)
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [DATA_W-1:0] reg_rdata_o,
    output logic irq_o,
    input wire logic serial_clk_i,
    input wire logic serial_select_n_i,
    input wire logic serial_in_i,
    output logic serial_out_o,
    input wire logic pwm_clock_i,
    input wire logic [1:0] direct_in_i,
    input wire logic [1:0] overcurrent_profile_select_i,
    input wire logic device_reset_n_i,
    input wire logic [1:0] overcurrent_i,
    input wire logic [1:0] short_circuit_i,
    input wire logic [1:0] overtemp_i,
    output logic switch_output_a_o,
    output logic switch_output_b_o,
    output logic [1:0] overcurrent_profile_o,
    output logic sense_temp_o,
    output logic sense_gain_o,
    output logic sense_chan_o,
    output logic sleep_o,
    output logic failsafe_indicator_n_o,
    output logic failsafe_indicator_n_oe_o,
    output logic fault_indicator_n_o,
    output logic fault_indicator_n_oe_o,
    output logic monitor_sync_n_o,
    output logic monitor_sync_n_oe_o
);
    logic [SY_W-1:0] sy;
    logic so_w, fr_ok, fr_bad;
    logic [FRAME_W-1:0] fr_w, tx_w;
    logic dev_rst, ext_q;
    logic [1:0] dir_in, trip;

    // Pin synchronisers; select and device reset idle high, all else low.
    dsc_sync #(.W(SY_W), .RST_VAL(SY_RST)) u_sync
    (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .d_i({overtemp_i, short_circuit_i, overcurrent_i, device_reset_n_i,
              overcurrent_profile_select_i, direct_in_i, pwm_clock_i,
              serial_in_i, serial_select_n_i, serial_clk_i}),
        .q_o(sy)
    );

    assign dev_rst = !sy[SY_RSTN];
    assign dir_in = sy[SY_IN+:2];
    assign trip = sy[SY_OC+:2] | sy[SY_SC+:2] | sy[SY_OT+:2];

    // Serial frame port.
    dsc_spi_rx u_spi
    (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .sclk_i(sy[SY_SCLK]),
        .csn_i(sy[SY_CSN]),
        .si_i(sy[SY_SI]),
        .tx_word_i(tx_w),
        .so_o(so_w),
        .frame_o(fr_w),
        .frame_ok_o(fr_ok),
        .frame_bad_o(fr_bad)
    );

    // Configuration and channel state.
    logic [3:0] mode_q, mode_d;
    logic [PWM_W-1:0] duty_q [2], duty_d [2];
    logic [2:0] sense_q, sense_d;
    logic [1:0] retry_q, retry_d;
    logic [1:0] fault_q, fault_d;
    logic [TMR_W-1:0] rtmr_q [2], rtmr_d [2];
    logic [TMR_W-1:0] wdog_q, wdog_d;
    logic fs_q, fs_d;
    logic [PWM_W-1:0] pint_q, pint_d, pext_q, pext_d;
    logic [SHORT_W-1:0] presc_q, presc_d, settle_q, settle_d;
    logic [1:0] on_q, on_d;
    logic fs_ev, flt_ev;
    logic [EV_W-1:0] stat_q, stat_d, mask_q, mask_d;
    logic [DATA_W-1:0] ctrl_q, ctrl_d, rdata_q, rdata_d;
    logic [FRAME_W-1:0] last_q, last_d;
    logic [EV_W-1:0] ev;

    // Mode field of one channel.
    function automatic logic [1:0] ch_mode(input logic [3:0] m, input int c);
        ch_mode = m[2*c+:2];
    endfunction

    assign tx_w = {DEV_ID, fs_q, fault_q, on_q, 7'h00};

    // Serial commands, fail-safe watchdog, PWM time bases, protection.
    always_comb
    begin
        mode_d = mode_q;
        duty_d = duty_q;
        sense_d = sense_q;
        retry_d = retry_q;
        fault_d = fault_q;
        rtmr_d = rtmr_q;
        fs_d = fs_q;
        wdog_d = wdog_q;
        on_d = on_q;
        pint_d = pint_q;
        pext_d = pext_q;
        presc_d = presc_q + 8'h01;
        settle_d = settle_q;
        if (presc_q == PWM_TICK_CYC[SHORT_W-1:0] - 8'h01)
        begin
            presc_d = '0;
            pint_d = pint_q + 8'h01;
        end
        if (sy[SY_PWMCLK] && !ext_q)
            pext_d = pext_q + 8'h01;
        if (fr_ok)
        begin
            case (fr_w[FR_CMD_HI:FR_CMD_LO])
                CMD_MODE: mode_d = fr_w[3:0];
                CMD_SENSE: sense_d = fr_w[2:0];
                CMD_DUTY_A: duty_d[0] = fr_w[PWM_W-1:0];
                CMD_DUTY_B: duty_d[1] = fr_w[PWM_W-1:0];
                CMD_RETRY: retry_d = fr_w[1:0];
                default: ;
            endcase
        end
        // Watchdog: no good frame in time means the host is gone.
        if (fr_ok)
        begin
            wdog_d = '0;
            fs_d = 1'b0;
        end
        else if (ctrl_q[CTRL_WDOG_EN] && !fs_q)
        begin
            if (wdog_q == TMR_W'(WDOG_CYCLES - 1))
                fs_d = 1'b1;
            else
                wdog_d = wdog_q + 20'h00001;
        end
        for (int c = 0; c < 2; c++)
        begin
            // Latch trips; retry timer releases the latch if enabled.
            if (fault_q[c] && retry_q[c])
            begin
                rtmr_d[c] = rtmr_q[c] + 20'h00001;
                if (rtmr_q[c] == TMR_W'(RETRY_CYCLES - 1))
                begin
                    rtmr_d[c] = '0;
                    fault_d[c] = 1'b0;
                end
            end
            if (trip[c])
                fault_d[c] = 1'b1;
            // Fail-safe hands control back to the direct inputs.
            if (fs_q || ch_mode(mode_q, c) == MODE_DIRECT)
                on_d[c] = dir_in[c];
            else if (ch_mode(mode_q, c) == MODE_INT)
                on_d[c] = pint_q < duty_q[c];
            else if (ch_mode(mode_q, c) == MODE_EXT)
                on_d[c] = pext_q < duty_q[c];
            else
                on_d[c] = 1'b0;
            if (fault_q[c])
                on_d[c] = 1'b0;
        end
        // Sense settles after the sensed channel has stayed on; temperature sense needs no channel on.
        if (sense_d != sense_q || (!sense_q[SENSE_TEMP] && !on_q[sense_q[SENSE_CHAN]]))
            settle_d = '0;
        else if (settle_q != SETTLE_CYC[SHORT_W-1:0])
            settle_d = settle_q + 8'h01;
        if (dev_rst)
        begin
            // Device reset pin restores configuration and faults.
            mode_d = '0;
            duty_d[0] = '0;
            duty_d[1] = '0;
            sense_d = '0;
            retry_d = '0;
            fault_d = '0;
            rtmr_d[0] = '0;
            rtmr_d[1] = '0;
            fs_d = 1'b0;
            wdog_d = '0;
        end
    end

    assign fs_ev = fs_d && !fs_q;
    assign flt_ev = (|fault_d) && !(|fault_q);

    // Registers of channel and configuration state.
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            mode_q <= '0;
            duty_q[0] <= '0;
            duty_q[1] <= '0;
            sense_q <= '0;
            retry_q <= '0;
            fault_q <= '0;
            rtmr_q[0] <= '0;
            rtmr_q[1] <= '0;
            fs_q <= 1'b0;
            wdog_q <= '0;
            on_q <= '0;
            pint_q <= '0;
            pext_q <= '0;
            presc_q <= '0;
            settle_q <= '0;
            ext_q <= 1'b0;
        end
        else
        begin
            mode_q <= mode_d;
            duty_q <= duty_d;
            sense_q <= sense_d;
            retry_q <= retry_d;
            fault_q <= fault_d;
            rtmr_q <= rtmr_d;
            fs_q <= fs_d;
            wdog_q <= wdog_d;
            on_q <= on_d;
            pint_q <= pint_d;
            pext_q <= pext_d;
            presc_q <= presc_d;
            settle_q <= settle_d;
            ext_q <= sy[SY_PWMCLK];
        end
    end

    // Software register file events.
    assign ev = {flt_ev, fs_ev, fr_bad, fr_ok};

    // Decode, read-to-clear status; a new event wins over the clear.
    always_comb
    begin
        mask_d = mask_q;
        ctrl_d = ctrl_q;
        last_d = fr_ok ? fr_w : last_q;
        stat_d = stat_q;
        rdata_d = '0;
        if (reg_wr_i && reg_addr_i == REG_MASK)
            mask_d = reg_wdata_i[EV_W-1:0];
        if (reg_wr_i && reg_addr_i == REG_CTRL)
            ctrl_d = reg_wdata_i;
        if (reg_rd_i)
        begin
            case (reg_addr_i)
                REG_STATUS:
                begin
                    rdata_d = {12'h000, stat_q};
                    stat_d = '0;
                end
                REG_MASK: rdata_d = {12'h000, mask_q};
                REG_CTRL: rdata_d = ctrl_q;
                REG_STATE: rdata_d = {7'h00, mode_q, fs_q, fault_q, on_q};
                REG_FRAME: rdata_d = last_q;
                default: rdata_d = '0;
            endcase
        end
        stat_d = stat_d | ev;
    end

    // Register bank and pin output flops.
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            stat_q <= '0;
            mask_q <= '0;
            ctrl_q <= CTRL_RST;
            last_q <= '0;
            rdata_q <= '0;
            irq_o <= 1'b0;
            serial_out_o <= 1'b0;
            switch_output_a_o <= 1'b0;
            switch_output_b_o <= 1'b0;
            overcurrent_profile_o <= '0;
            sense_temp_o <= 1'b0;
            sense_gain_o <= 1'b0;
            sense_chan_o <= 1'b0;
            sleep_o <= 1'b0;
            failsafe_indicator_n_o <= 1'b1;
            failsafe_indicator_n_oe_o <= 1'b0;
            fault_indicator_n_o <= 1'b1;
            fault_indicator_n_oe_o <= 1'b0;
            monitor_sync_n_o <= 1'b1;
            monitor_sync_n_oe_o <= 1'b0;
        end
        else
        begin
            stat_q <= stat_d;
            mask_q <= mask_d;
            ctrl_q <= ctrl_d;
            last_q <= last_d;
            rdata_q <= rdata_d;
            irq_o <= |(stat_d & mask_d);
            serial_out_o <= so_w;
            switch_output_a_o <= on_d[0];
            switch_output_b_o <= on_d[1];
            overcurrent_profile_o <= sy[SY_PROF+:2];
            sense_temp_o <= sense_d[SENSE_TEMP];
            sense_gain_o <= sense_d[SENSE_GAIN];
            sense_chan_o <= sense_d[SENSE_CHAN];
            sleep_o <= dev_rst && !(|dir_in);
            failsafe_indicator_n_o <= !fs_d;
            failsafe_indicator_n_oe_o <= fs_d;
            fault_indicator_n_o <= !(|fault_d);
            fault_indicator_n_oe_o <= |fault_d;
            monitor_sync_n_o <= settle_d != SETTLE_CYC[SHORT_W-1:0];
            monitor_sync_n_oe_o <= settle_d == SETTLE_CYC[SHORT_W-1:0];
        end
    end

    assign reg_rdata_o = rdata_q;
endmodule // dsc_top

// >>> dsc_top_asserts.sv
// Concurrent checks on the pins of the dual switch control block.
`timescale 1ns/1ps
module dsc_top_asserts
    import dsc_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [1:0] direct_in_i,
    input wire logic [1:0] overcurrent_profile_select_i,
    input wire logic device_reset_n_i,
    input wire logic [1:0] overcurrent_i,
    input wire logic [1:0] short_circuit_i,
    input wire logic [1:0] overtemp_i,
    input wire logic switch_output_a_o,
    input wire logic switch_output_b_o,
    input wire logic [1:0] overcurrent_profile_o,
    input wire logic sleep_o,
    input wire logic failsafe_indicator_n_o,
    input wire logic failsafe_indicator_n_oe_o,
    input wire logic fault_indicator_n_o,
    input wire logic fault_indicator_n_oe_o,
    input wire logic monitor_sync_n_o,
    input wire logic monitor_sync_n_oe_o
);
    logic [2:0] up_q, up_d;
    logic up;
    // Cycles since reset, so windows never reach into it.
    always_comb
    begin
        up_d = (up_q == 3'h7) ? up_q : up_q + 3'h1;
    end
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            up_q <= 3'h0;
        else
            up_q <= up_d;
    end
    assign up = (up_q == 3'h7);
    default clocking dcb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    // Open-drain pins pull low exactly while enabled.
    fs_pin_a: assert property (failsafe_indicator_n_o == !failsafe_indicator_n_oe_o)
        else $error("Fail-safe pin mismatch");
    fault_pin_a: assert property (fault_indicator_n_o == !fault_indicator_n_oe_o)
        else $error("Fault pin mismatch");
    sync_pin_a: assert property (monitor_sync_n_o == !monitor_sync_n_oe_o)
        else $error("Sync pin mismatch");
    // Sleep follows device reset unless a direct input is on.
    stay_awake_a: assert property ((direct_in_i != 2'h0)[*5] |-> !sleep_o)
        else $error("Asleep with direct input on");
    go_sleep_a: assert property ((!device_reset_n_i && direct_in_i == 2'h0)[*6] ##0 up |-> sleep_o)
        else $error("Awake in device reset");
    profile_sel_a: assert property ($stable(overcurrent_profile_select_i)[*5] ##0 up
        |-> overcurrent_profile_o == overcurrent_profile_select_i)
        else $error("Profile not following pins");
    // A trip turns its channel off.
    trip_off_a: assert property ((overcurrent_i[0] || short_circuit_i[0] || overtemp_i[0])[*5]
        |-> !switch_output_a_o)
        else $error("Channel A on during a trip");
    b_trip_off_a: assert property ((overcurrent_i[1] || short_circuit_i[1] || overtemp_i[1])[*5]
        |-> !switch_output_b_o)
        else $error("Channel B on during a trip");
    fault_set_a: assert property ((device_reset_n_i
        && (overcurrent_i | short_circuit_i | overtemp_i) != 2'h0)[*6] |-> fault_indicator_n_oe_o)
        else $error("Fault pin released in trip");
    dev_reset_a: assert property ((!device_reset_n_i
        && (overcurrent_i | short_circuit_i | overtemp_i) == 2'h0)[*6] ##0 up
        |-> !fault_indicator_n_oe_o && !failsafe_indicator_n_oe_o)
        else $error("Held through device reset");
endmodule // dsc_top_asserts

// >>> dsc_top_tb_top.sv
// Self-checking bench for the dual switch control block.
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_total++; \
    $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module dsc_top_tb_top
    import dsc_pkg::*;
;
    localparam int WD = 200;
    localparam int RT = 100;
    localparam logic [3:0] TB_ID = 4'h6; // Arbitrary value.
    logic mclk_i, rst_i, reg_wr_i, reg_rd_i, irq_o, serial_clk_i, serial_select_n_i;
    logic serial_in_i, serial_out_o, pwm_clock_i, device_reset_n_i, switch_output_a_o;
    logic switch_output_b_o, sense_temp_o, sense_gain_o, sense_chan_o, sleep_o;
    logic failsafe_indicator_n_o, failsafe_indicator_n_oe_o, fault_indicator_n_o;
    logic fault_indicator_n_oe_o, monitor_sync_n_o, monitor_sync_n_oe_o;
    logic [ADDR_W-1:0] reg_addr_i;
    logic [DATA_W-1:0] reg_wdata_i, reg_rdata_o, d;
    logic [1:0] direct_in_i, overcurrent_profile_select_i, overcurrent_i, short_circuit_i;
    logic [1:0] overtemp_i, overcurrent_profile_o;
    logic [31:0] r, w;
    logic [2:0] sv;
    int err_total, checks_done, cnt, da, db;
    dsc_top #(.WDOG_CYCLES(WD), .RETRY_CYCLES(RT), .DEV_ID(TB_ID)) dut (.*);
    dsc_host_model host (.sclk_o(serial_clk_i), .csn_o(serial_select_n_i),
        .si_o(serial_in_i), .so_i(serial_out_o));
    // System clock at 50 MHz.
    initial
    begin
        mclk_i = 1'b0;
        forever #10 mclk_i = ~mclk_i;
    end
    // Expected serial response word.
    function automatic logic [15:0] exp_resp(input logic fs, input logic [1:0] on);
        return {TB_ID, fs, 2'b00, on, 7'h00};
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_i);
    endtask
    // Register accesses, one strobe cycle each.
    task automatic wr(input logic [4:0] a, input logic [15:0] v);
        @(posedge mclk_i);
        {reg_addr_i, reg_wdata_i, reg_wr_i} <= {a, v, 1'b1};
        @(posedge mclk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, output logic [15:0] q);
        @(posedge mclk_i);
        {reg_addr_i, reg_rd_i} <= {a, 1'b1};
        @(posedge mclk_i);
        reg_rd_i <= 1'b0;
        #1;
        q = reg_rdata_o;
    endtask
    task automatic frm(input logic [3:0] c, input logic [11:0] v);
        host.xfer({16'h0000, c, v}, 16, r);
        cyc(8);
    endtask
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Tests take about 29300 cycles; the limit is 50000.
    initial
    begin
        #1_000_000;
        err_total++;
        complete_run();
    end
    initial
    begin
        {rst_i, reg_wr_i, reg_rd_i, pwm_clock_i, device_reset_n_i} = 5'h11;
        {reg_addr_i, reg_wdata_i} = '0;
        {direct_in_i, overcurrent_profile_select_i, overcurrent_i, short_circuit_i} = '0;
        overtemp_i = 2'h0;
        d = 16'($urandom(32'ha0fd));
        cyc(5);
        rst_i <= 1'b0;
        wr(5'h14, 16'hffff);
        rd(REG_MASK, d); `CHK(d, 16'h0000)
        rd(REG_CTRL, d); `CHK(d, CTRL_RST)
        rd(5'h14, d); `CHK(d, 16'h0000)
        $display("Test reset values done");
        cyc(WD + 20);
        `CHK({failsafe_indicator_n_oe_o, failsafe_indicator_n_o, irq_o}, 3'b100)
        wr(REG_MASK, 16'h0004);
        cyc(2);
        `CHK(irq_o, 1'b1)
        rd(REG_STATUS, d); `CHK(d, 16'h0004)
        cyc(2);
        `CHK(irq_o, 1'b0)
        for (int i = 0; i < 4; i++)
        begin
            direct_in_i <= 2'(i);
            sv = 3'($urandom);
            overcurrent_profile_select_i <= sv[1:0];
            cyc(6);
            `CHK({switch_output_b_o, switch_output_a_o}, 2'(i))
            `CHK(overcurrent_profile_o, sv[1:0])
        end
        $display("Test fail-safe done");
        sv = 3'($urandom) | 3'h1;
        w = {16'h0000, CMD_SENSE, 9'h000, sv};
        host.xfer(w, 16, r);
        cyc(8);
        `CHK(r[15:0], exp_resp(1'b1, 2'h3))
        `CHK({sense_chan_o, sense_gain_o, sense_temp_o}, sv)
        `CHK(failsafe_indicator_n_oe_o, 1'b0)
        rd(REG_STATUS, d); `CHK(d, 16'h0001)
        rd(REG_FRAME, d); `CHK(d, w[15:0])
        wr(REG_CTRL, 16'h0000);
        w = {CMD_SENSE, 12'h000, 16'($urandom)};
        host.xfer(w, 32, r);
        cyc(8);
        `CHK(r, {exp_resp(1'b0, 2'h3), w[31:16]})
        `CHK({sense_chan_o, sense_gain_o, sense_temp_o}, sv)
        rd(REG_STATUS, d); `CHK(d, 16'h0002)
        `CHK({monitor_sync_n_oe_o, monitor_sync_n_o}, 2'b10)
        $display("Test frames done");
        frm(CMD_MODE, 12'h009);
        da = $urandom_range(254, 1);
        db = $urandom_range(254, 1);
        frm(CMD_DUTY_A, 12'(da));
        frm(CMD_DUTY_B, 12'(db));
        cnt = 0;
        repeat (256)
        begin
            cyc(PWM_TICK_CYC);
            if (switch_output_a_o === 1'b1) cnt++;
        end
        `CHK(cnt, da)
        cnt = 0;
        repeat (256)
        begin
            pwm_clock_i <= 1'b1;
            cyc(4);
            pwm_clock_i <= 1'b0;
            cyc(3);
            if (switch_output_b_o === 1'b1) cnt++;
            cyc(1);
        end
        `CHK(cnt, db)
        $display("Test clocked modes done");
        frm(CMD_MODE, 12'h000);
        frm(CMD_RETRY, 12'h001);
        {overtemp_i[0], short_circuit_i[0], overcurrent_i[0]} <= 3'b001 << $urandom_range(2, 0);
        {overtemp_i[1], short_circuit_i[1], overcurrent_i[1]} <= 3'b001 << $urandom_range(2, 0);
        cyc(10);
        {overtemp_i, short_circuit_i, overcurrent_i} <= 6'h00;
        cyc(6);
        `CHK({switch_output_b_o, switch_output_a_o, fault_indicator_n_oe_o}, 3'b001)
        rd(REG_STATUS, d); `CHK(d[EV_FAULT], 1'b1)
        cyc(RT + 20);
        `CHK({switch_output_b_o, switch_output_a_o}, 2'b01)
        $display("Test protection done");
        direct_in_i <= 2'b00;
        device_reset_n_i <= 1'b0;
        cyc(10);
        `CHK({sleep_o, fault_indicator_n_oe_o}, 2'b10)
        `CHK({sense_chan_o, sense_gain_o, sense_temp_o}, 3'b000)
        direct_in_i <= 2'b10;
        cyc(6);
        `CHK(sleep_o, 1'b0)
        device_reset_n_i <= 1'b1;
        direct_in_i <= 2'b11;
        cyc(8);
        `CHK({switch_output_b_o, switch_output_a_o}, 2'b11)
        $display("Test device reset done");
        complete_run();
    end
endmodule // dsc_top_tb_top
bind dsc_top dsc_top_asserts chk (.*);
